// ### core/stamp_pkg.sv
/*
 * Shared constants and types for the sample stamp post-processor.
 * Assumes one clock domain; no tool-specific settings.
 */
package stamp_pkg;
  // ---------------------------------------------------------------------
  // Field layout of one sample record
  // ---------------------------------------------------------------------
  localparam int TIME_W = 32;
  localparam int EVENT_W = 32;
  localparam int INTERP_W = 8;
  localparam int BLOCK_START_BIT = 6;
  localparam int INHIBIT_BIT = 7;
  localparam int INTERP_VAL_W = 6;
  // Stamps in units of 0.1 ns
  localparam int STAMP_W = 48;
  localparam int COARSE_PS = 2000;
  localparam int FINE_PS = 100;
  localparam int UNIT_PS = 100;
  localparam logic [7:0] COARSE_MULT = 8'(COARSE_PS / UNIT_PS);
  localparam logic [7:0] FINE_MULT = 8'(FINE_PS / UNIT_PS);
  localparam int EVENT_SCALE_SHIFT = 2;
  localparam int QUOT_FRAC_W = 16;
  localparam int DIV_STEPS = STAMP_W + QUOT_FRAC_W;

  // ---------------------------------------------------------------------
  // Modes, result kinds and divider states
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    FUNC_CONT_TI = 2'h0,
    FUNC_FREQ = 2'h1,
    FUNC_PERIOD = 2'h2,
    FUNC_START_STOP = 2'h3
  } func_e;

  typedef enum logic [1:0] {
    RES_ARMING = 2'h0,
    RES_INTERVAL = 2'h1,
    RES_QUOTIENT = 2'h2
  } result_kind_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIVIDE = 2'b01,
    ST_DONE = 2'b11
  } div_state_e;
endpackage

// ### core/stamp_if.sv
/*
 * Carries one corrected stamp pair from the stamp builder to the
 * result stage. Same clock for both ends.
 */
`timescale 1ns/1ps
interface stamp_if;
  import stamp_pkg::*;
  logic valid;
  logic first;
  logic [STAMP_W-1:0] stamp;
  logic [EVENT_W+1:0] events;
  modport src (output valid, output first, output stamp, output events);
  modport dst (input valid, input first, input stamp, input events);
endinterface

// ### core/stamp_builder.sv
/*
 * Builds corrected time and event stamps from raw sample records.
 * Assumes records arrive from logic on the same clock, one per valid.
 */
`timescale 1ns/1ps
module stamp_builder
  import stamp_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic rec_valid_in,
  input wire logic [TIME_W-1:0] rec_time_in,
  input wire logic [EVENT_W-1:0] rec_event_in,
  input wire logic [INTERP_W-1:0] rec_interp_in,
  input wire logic start_stop_in,
  input wire logic chan_c_in,
  input wire logic [STAMP_W-1:0] time_ovf_in,
  input wire logic [EVENT_W+1:0] event_ovf_in,
  input wire logic [STAMP_W-1:0] path_offset_in,
  stamp_if.src out
);
  // ---------------------------------------------------------------------
  // Rollover tracking
  // ---------------------------------------------------------------------
  logic [TIME_W-1:0] last_time;
  logic [EVENT_W-1:0] last_event;
  logic [STAMP_W-1:0] time_acc;
  logic [EVENT_W+1:0] event_acc;
  logic have_prev;
  logic stop_phase;
  logic [STAMP_W-1:0] stamp_q;
  logic [EVENT_W+1:0] events_q;
  logic valid_q;
  logic first_q;

  wire block_start = rec_interp_in[BLOCK_START_BIT];
  wire time_roll = have_prev && (rec_time_in < last_time);
  wire event_roll = have_prev && !block_start && !start_stop_in
                    && (rec_event_in < last_event);
  wire [STAMP_W-1:0] next_time_acc = time_roll ? time_acc + time_ovf_in
                                               : time_acc;
  wire [EVENT_W+1:0] next_event_acc = event_roll
                                      ? event_acc + event_ovf_in
                                      : event_acc;
  wire [STAMP_W-1:0] coarse = STAMP_W'(rec_time_in) + next_time_acc;
  wire [EVENT_W+1:0] ev_fixed = (EVENT_W+2)'(rec_event_in)
                                + next_event_acc;
  // Rollover first, then scaling
  wire [EVENT_W+1:0] ev_scaled = chan_c_in
                                 ? ev_fixed << EVENT_SCALE_SHIFT
                                 : ev_fixed;
  wire [STAMP_W-1:0] fine_part = STAMP_W'(rec_interp_in[INTERP_VAL_W-1:0])
                                 * STAMP_W'(FINE_MULT);
  wire [STAMP_W-1:0] raw_stamp = coarse * STAMP_W'(COARSE_MULT)
                                 - fine_part;
  wire [STAMP_W-1:0] cont_stamp = block_start ? raw_stamp - path_offset_in
                                              : raw_stamp;
  wire [STAMP_W-1:0] ss_stamp = stop_phase ? raw_stamp + path_offset_in
                                           : raw_stamp;

  assign out.valid = valid_q;
  assign out.first = first_q;
  assign out.stamp = stamp_q;
  assign out.events = events_q;

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      last_time <= '0;
      last_event <= '0;
      time_acc <= '0;
      event_acc <= '0;
      have_prev <= 1'b0;
      stop_phase <= 1'b0;
      stamp_q <= '0;
      events_q <= '0;
      valid_q <= 1'b0;
      first_q <= 1'b0;
    end else begin
      valid_q <= rec_valid_in;
      if (rec_valid_in) begin
        last_time <= rec_time_in;
        if (!block_start && !start_stop_in) begin
          last_event <= rec_event_in;
        end
        time_acc <= next_time_acc;
        event_acc <= next_event_acc;
        have_prev <= 1'b1;
        stop_phase <= start_stop_in ? !stop_phase : 1'b0;
        stamp_q <= start_stop_in ? ss_stamp : cont_stamp;
        events_q <= ev_scaled;
        first_q <= start_stop_in ? !stop_phase : block_start;
      end
    end
  end
endmodule

// ### core/ratio_divider.sv
/*
 * Unsigned restoring divider producing a fixed-point quotient.
 * Assumes a start pulse only while not busy.
 */
`timescale 1ns/1ps
module ratio_divider
  import stamp_pkg::*;
#(
  parameter int WIDTH = STAMP_W,
  parameter int FRAC = QUOT_FRAC_W
)
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic start_in,
  input wire logic [WIDTH-1:0] num_in,
  input wire logic [WIDTH-1:0] den_in,
  output logic busy_out,
  output logic done_out,
  output logic [WIDTH-1:0] quot_out
);
  if (WIDTH < 2 || FRAC < 1 || FRAC >= WIDTH) begin : g_bad_width
    $error("ratio_divider: unsupported widths");
  end

  localparam int STEPS = WIDTH + FRAC;
  div_state_e state;
  logic [WIDTH+FRAC-1:0] dividend;
  logic [WIDTH:0] rem;
  logic [WIDTH-1:0] den;
  logic [$clog2(STEPS+1)-1:0] count;

  wire [WIDTH:0] shifted = {rem[WIDTH-1:0], dividend[WIDTH+FRAC-1]};
  wire [WIDTH:0] trial = shifted - {1'b0, den};
  wire fits = !trial[WIDTH];

  assign busy_out = (state != ST_IDLE);

  // ---------------------------------------------------------------------
  // Iteration
  // ---------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state <= ST_IDLE;
      dividend <= '0;
      rem <= '0;
      den <= '0;
      count <= '0;
      done_out <= 1'b0;
      quot_out <= '0;
    end else begin
      done_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_in) begin
            dividend <= {num_in, FRAC'(0)};
            rem <= '0;
            den <= den_in;
            count <= '0;
            state <= ST_DIVIDE;
          end
        end
        ST_DIVIDE: begin
          rem <= fits ? trial : shifted;
          dividend <= {dividend[WIDTH+FRAC-2:0], fits};
          count <= count + 1'b1;
          if (count == ($clog2(STEPS+1))'(STEPS-1)) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          quot_out <= (den == '0) ? '1 : dividend[WIDTH-1:0];
          done_out <= 1'b1;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

// ### core/sample_stamp_postprocessor.sv
/*
 * Post-processor that turns the analyzer's binary sample stream into
 * stamps and final results. Assumes records come from same-clock logic
 * and configuration stays constant during a block.
 */
// Summary of operation
// - Lower event count adds event overflow; block-start samples skipped.
// - Third channel event stamps are multiplied by four after rollover fix.
// - Any time count below predecessor adds time overflow from then on.
// - Stamp is coarse count times 2 ns minus interpolator times 0.1 ns.
// - Order: rollover fix, interpolator merge, path correction.
// - Continuous format subtracts offset from block's first stamp only.
// - Block arming result is first channel stamp minus arming stamp.
// - Interval result is next stamp minus current stamp per pair.
// - Missed events are event stamp difference minus one.
// - Frequency is events over time; period is time over events.
// - Gate time is difference of consecutive time stamps.
// - Start/stop format adds path offset to every stop stamp.
// - Start/stop interval is corrected stop minus start of same pair.
`timescale 1ns/1ps
module sample_stamp_postprocessor
  import stamp_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic rec_valid_in,
  input wire logic [TIME_W-1:0] rec_time_in,
  input wire logic [EVENT_W-1:0] rec_event_in,
  input wire logic [INTERP_W-1:0] rec_interp_in,
  input wire logic [1:0] func_in,
  input wire logic expanded_in,
  input wire logic chan_c_in,
  input wire logic [STAMP_W-1:0] time_ovf_in,
  input wire logic [EVENT_W+1:0] event_ovf_in,
  input wire logic [STAMP_W-1:0] path_offset_in,
  output logic rec_ready_out,
  output logic res_valid_out,
  output logic [1:0] res_kind_out,
  output logic [STAMP_W-1:0] res_value_out,
  output logic res_aux_valid_out,
  output logic [STAMP_W-1:0] res_aux_out,
  output logic res_inhibit_out
);
  // ---------------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------------
  wire start_stop = (func_in == FUNC_START_STOP);
  wire quot_mode = (func_in == FUNC_FREQ) || (func_in == FUNC_PERIOD);
  wire div_busy;
  wire div_done;
  wire [STAMP_W-1:0] div_quot;
  logic div_pending;
  // Quotient modes hold off new records while dividing
  assign rec_ready_out = !(div_busy || div_pending);
  wire rec_take = rec_valid_in && rec_ready_out;
  // Inhibit bit is cleared from the record sent to the stamp builder in start/stop format
  wire [INTERP_W-1:0] interp_clean = start_stop
      ? (rec_interp_in & ~(INTERP_W'(1) << INHIBIT_BIT))
      : rec_interp_in;
  logic inhibit_q;

  // ---------------------------------------------------------------------
  // Stamp building
  // ---------------------------------------------------------------------
  stamp_if st ();

  stamp_builder u_build (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .rec_valid_in(rec_take),
    .rec_time_in(rec_time_in),
    // No event counts exist in start/stop format
    .rec_event_in(start_stop ? '0 : rec_event_in),
    .rec_interp_in(interp_clean),
    .start_stop_in(start_stop),
    .chan_c_in(chan_c_in),
    .time_ovf_in(time_ovf_in),
    .event_ovf_in(event_ovf_in),
    .path_offset_in(path_offset_in),
    .out(st)
  );

  // ---------------------------------------------------------------------
  // Previous stamp and result arithmetic
  // ---------------------------------------------------------------------
  logic [STAMP_W-1:0] prev_stamp;
  logic [EVENT_W+1:0] prev_events;
  logic prev_was_arming;
  logic have_prev;

  wire [STAMP_W-1:0] dt = st.stamp - prev_stamp;
  wire [EVENT_W+1:0] de = st.events - prev_events;
  wire [STAMP_W-1:0] de_w = STAMP_W'(de);
  wire [STAMP_W-1:0] missed = de_w - STAMP_W'(1);
  // Arming sample has no event data; its pair yields only arming time
  wire pair_ok = st.valid && have_prev && !st.first;
  wire arming_pair = pair_ok && prev_was_arming && !start_stop;
  wire div_start = pair_ok && !arming_pair && quot_mode;
  wire [STAMP_W-1:0] num_sel = (func_in == FUNC_FREQ) ? de_w : dt;
  wire [STAMP_W-1:0] den_sel = (func_in == FUNC_FREQ) ? dt : de_w;
  logic [STAMP_W-1:0] gate_hold;

  ratio_divider #(
    .WIDTH(STAMP_W),
    .FRAC(QUOT_FRAC_W)
  ) u_div (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .start_in(div_start),
    .num_in(num_sel),
    .den_in(den_sel),
    .busy_out(div_busy),
    .done_out(div_done),
    .quot_out(div_quot)
  );

  // ---------------------------------------------------------------------
  // Pair bookkeeping
  // ---------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      prev_stamp <= '0;
      prev_events <= '0;
      prev_was_arming <= 1'b0;
      have_prev <= 1'b0;
      div_pending <= 1'b0;
      gate_hold <= '0;
      inhibit_q <= 1'b0;
    end else begin
      if (rec_take) begin
        inhibit_q <= rec_interp_in[INHIBIT_BIT];
      end
      if (rec_take && quot_mode) begin
        div_pending <= 1'b1;
      end else if (st.valid && !div_start) begin
        div_pending <= 1'b0;
      end else if (div_start) begin
        div_pending <= 1'b0;
      end
      if (div_start) begin
        gate_hold <= dt;
      end
      if (st.valid) begin
        prev_stamp <= st.stamp;
        prev_events <= st.events;
        prev_was_arming <= st.first;
        have_prev <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Result output
  // ---------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      res_valid_out <= 1'b0;
      res_kind_out <= RES_ARMING;
      res_value_out <= '0;
      res_aux_valid_out <= 1'b0;
      res_aux_out <= '0;
      res_inhibit_out <= 1'b0;
    end else begin
      res_valid_out <= 1'b0;
      res_aux_valid_out <= 1'b0;
      if (div_done) begin
        res_valid_out <= 1'b1;
        res_kind_out <= RES_QUOTIENT;
        res_value_out <= div_quot;
        res_aux_valid_out <= expanded_in;
        res_aux_out <= gate_hold;
      end else if (arming_pair) begin
        res_valid_out <= 1'b1;
        res_kind_out <= RES_ARMING;
        res_value_out <= dt;
        res_inhibit_out <= inhibit_q;
      end else if (pair_ok && !quot_mode) begin
        res_valid_out <= 1'b1;
        res_kind_out <= RES_INTERVAL;
        res_value_out <= dt;
        res_aux_valid_out <= expanded_in && !start_stop;
        res_aux_out <= missed;
        res_inhibit_out <= inhibit_q;
      end
    end
  end
endmodule

// ### bench/stamp_properties.sv
/*
 * Port checker for the sample stamp post-processor.
 * Assumes one clock and the synchronous active-high reset.
 */
`timescale 1ns/1ps
module stamp_properties
  import stamp_pkg::*;
(
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic rec_valid_in,
  input wire logic [INTERP_W-1:0] rec_interp_in,
  input wire logic [1:0] func_in,
  input wire logic expanded_in,
  input wire logic rec_ready_out,
  input wire logic res_valid_out,
  input wire logic [1:0] res_kind_out,
  input wire logic [STAMP_W-1:0] res_value_out,
  input wire logic res_aux_valid_out
);
  wire take = rec_valid_in && rec_ready_out;
  wire bs = rec_interp_in[BLOCK_START_BIT];
  wire cont = func_in == FUNC_CONT_TI;
  wire quot = res_valid_out && res_kind_out == RES_QUOTIENT;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  a_arming_pair: assert property (
    (take && bs && cont) ##1 (take && !bs && cont)
    |-> ##2 (res_valid_out && res_kind_out == RES_ARMING))
    else $error("arming result missing");
  a_interval_pair: assert property (
    (take && !bs && cont) ##1 (take && !bs && cont)
    |-> ##2 (res_valid_out && res_kind_out == RES_INTERVAL))
    else $error("interval result missing");
  a_block_first_quiet: assert property (
    take && bs && cont |-> ##2 !res_valid_out)
    else $error("result closed on block start");
  a_missed_flag: assert property (
    res_valid_out && cont && res_kind_out == RES_INTERVAL
    |-> res_aux_valid_out == expanded_in)
    else $error("missed event flag wrong");
  a_gate_flag: assert property (
    quot |-> res_aux_valid_out == expanded_in)
    else $error("gate time flag wrong");
  a_quot_mode: assert property (
    quot |-> func_in inside {FUNC_FREQ, FUNC_PERIOD})
    else $error("quotient outside ratio modes");
  a_ready_back: assert property (
    !rec_ready_out |-> ##[1:100] rec_ready_out)
    else $error("ready stuck low");
  a_stop_result: assert property (
    res_valid_out && func_in == FUNC_START_STOP
    |-> res_kind_out == RES_INTERVAL && !res_aux_valid_out
    && $past(take, 2))
    else $error("start stop result malformed");
  a_value_hold: assert property (
    !res_valid_out |-> $stable(res_value_out))
    else $error("result value moved");
endmodule

bind sample_stamp_postprocessor stamp_properties chk (
  .clock_in(clock_in), .sys_rst_in(sys_rst_in),
  .rec_valid_in(rec_valid_in), .rec_interp_in(rec_interp_in),
  .func_in(func_in), .expanded_in(expanded_in),
  .rec_ready_out(rec_ready_out), .res_valid_out(res_valid_out),
  .res_kind_out(res_kind_out), .res_value_out(res_value_out),
  .res_aux_valid_out(res_aux_valid_out));

// ### bench/sample_source.sv
/*
 * Behavioural instrument that delivers sample records.
 * Assumes the caller steps just after a rising clock edge.
 */
`timescale 1ns/1ps
module sample_source
  import stamp_pkg::*;
(
  input wire logic clock_in,
  input wire logic ready_in,
  output logic valid_out,
  output logic [TIME_W-1:0] time_out,
  output logic [EVENT_W-1:0] event_out,
  output logic [INTERP_W-1:0] interp_out
);
  int n_stuck = 0;
  initial begin
    valid_out = 1'b0;
    time_out = '0;
    event_out = '0;
    interp_out = '0;
  end
  task automatic send(input logic [TIME_W-1:0] t,
    input logic [EVENT_W-1:0] e, input logic bs, input logic inh,
    input logic ss, input logic [5:0] fine);
    int n;
    n = 0;
    valid_out = 1'b1;
    time_out = t;
    event_out = (bs || ss) ? '0 : e;
    interp_out = {inh, bs, fine};
    while (!ready_in && n < 200) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    if (n == 200) n_stuck++;
    @(posedge clock_in);
    #1;
  endtask
  // Released lines show the inverse of their last value
  task automatic idle();
    valid_out = 1'b0;
    time_out = ~time_out;
    event_out = ~event_out;
    interp_out = ~interp_out;
  endtask
endmodule

// ### bench/testbench.sv
/*
 * Self-checking bench for the sample stamp post-processor.
 * Assumes the record source model and the bound checker.
 */
`timescale 1ns/1ps
module testbench
  import stamp_pkg::*;
;
  typedef struct {logic [1:0] k; logic [STAMP_W-1:0] v; logic av;
    logic [STAMP_W-1:0] a; logic inh;} res_s;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic rv, rdy, expanded = 1'b0, chan_c = 1'b0;
  logic [1:0] func = 2'h0;
  logic [STAMP_W-1:0] off = '0;
  logic [TIME_W-1:0] rt;
  logic [EVENT_W-1:0] re;
  logic [INTERP_W-1:0] ri;
  logic resv, auxv, rinh;
  logic [1:0] kind;
  logic [STAMP_W-1:0] val, aux;
  int n_mismatch = 0, checks_done = 0;
  longint pt = -1, acc_t = 0, pe = -1, acc_e = 0;
  longint s[$], ev[$];
  res_s q[$];
  res_s r;

  always #4 clock_in = ~clock_in;
  always @(negedge clock_in)
    if (resv === 1'b1) q.push_back('{kind, val, auxv, aux, rinh});

  sample_source src (.clock_in(clock_in), .ready_in(rdy),
    .valid_out(rv), .time_out(rt), .event_out(re), .interp_out(ri));
  sample_stamp_postprocessor uut (.clock_in(clock_in),
    .sys_rst_in(sys_rst_in), .rec_valid_in(rv), .rec_time_in(rt),
    .rec_event_in(re), .rec_interp_in(ri), .func_in(func),
    .expanded_in(expanded), .chan_c_in(chan_c),
    .time_ovf_in(48'h1000), .event_ovf_in(34'h100),
    .path_offset_in(off), .rec_ready_out(rdy), .res_valid_out(resv),
    .res_kind_out(kind), .res_value_out(val),
    .res_aux_valid_out(auxv), .res_aux_out(aux),
    .res_inhibit_out(rinh));

  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    n_mismatch += src.n_stuck;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cfg(logic [1:0] f, logic x, logic c, logic [47:0] o);
    func = f;
    expanded = x;
    chan_c = c;
    off = o;
    s.delete();
    ev.delete();
  endtask
  task automatic put(longint t, longint e, bit bs, bit inh, bit ss,
    longint fine);
    if (pt >= 0 && t < pt) acc_t += 'h1000;
    pt = t;
    s.push_back(20 * (t + acc_t) - fine
      - ((bs && !ss) ? longint'(off) : 0));
    if (!bs && !ss) begin
      if (pe >= 0 && e < pe) acc_e += 'h100;
      pe = e;
    end
    ev.push_back((e + acc_e) * (chan_c ? 4 : 1));
    src.send(32'(t), 32'(e), bs, inh, ss, 6'(fine));
  endtask
  task automatic collect(int n);
    int w;
    src.idle();
    w = 0;
    while (q.size() < n && w < 300) begin
      @(posedge clock_in);
      #1;
      w++;
    end
    repeat (4) @(posedge clock_in);
    #1;
    if (w == 300) begin
      n_mismatch++;
      conclude();
    end
    check("result count", q.size(), n);
  endtask
  task automatic judge_cont(int n);
    for (int i = 0; i < n && q.size() > 0; i++) begin
      r = q.pop_front();
      check("kind", r.k, i ? RES_INTERVAL : RES_ARMING);
      check("interval", r.v, 48'(s[i+1] - s[i]));
      if (i > 0) check("missed", r.a, 48'(ev[i+1] - ev[i] - 1));
    end
  endtask
  task automatic judge_ratio(bit per, bit x);
    longint dt, de, qx;
    dt = s[2] - s[1];
    de = ev[2] - ev[1];
    qx = per ? (dt << 16) / de : (de << 16) / dt;
    r = q.pop_front();
    check("arming", r.v, 48'(s[1] - s[0]));
    r = q.pop_front();
    check("quotient kind", r.k, RES_QUOTIENT);
    check("quotient", r.v, 48'(qx));
    check("gate flag", r.av, x);
    if (x) check("gate time", r.a, 48'(dt));
  endtask

  task automatic cont_interval();
    cfg(FUNC_CONT_TI, 1'b1, 1'b0, 48'h64);
    put('h100, 0, 1, 0, 0, 5);
    put('h110, 'h10, 0, 0, 0, 3);
    put('h120, 'h13, 0, 0, 0, 0);
    put('hfff, 'h20, 0, 0, 0, 63);
    put('h8, 'h28, 0, 0, 0, 1);
    collect(4);
    judge_cont(4);
  endtask
  task automatic event_rollover();
    cfg(FUNC_CONT_TI, 1'b1, 1'b1, 48'h0);
    put('h20, 0, 1, 0, 0, 2);
    put('h30, 'hf0, 0, 0, 0, 7);
    put('h40, 'h08, 0, 0, 0, 1);
    put('h50, 'h10, 0, 0, 0, 0);
    collect(3);
    judge_cont(3);
  endtask
  task automatic period_ratio();
    cfg(FUNC_PERIOD, 1'b1, 1'b0, 48'h10);
    put('h60, 0, 1, 0, 0, 2);
    put('h70, 'h120, 0, 0, 0, 4);
    put('h90, 'h124, 0, 0, 0, 7);
    collect(2);
    judge_ratio(1'b1, 1'b1);
  endtask
  task automatic freq_ratio();
    cfg(FUNC_FREQ, 1'b0, 1'b0, 48'h0);
    put('ha0, 0, 1, 0, 0, 0);
    put('hb0, 'h130, 0, 0, 0, 3);
    put('h100, 'h13a, 0, 0, 0, 9);
    collect(2);
    judge_ratio(1'b0, 1'b0);
  endtask
  task automatic start_stop();
    cfg(FUNC_START_STOP, 1'b0, 1'b0, 48'h32);
    put('h110, 5, 1, 0, 1, 2);
    put('h118, 6, 0, 0, 1, 9);
    put('h120, 7, 0, 0, 1, 0);
    put('h128, 8, 0, 1, 1, 4);
    collect(2);
    for (int i = 0; i < 2 && q.size() > 0; i++) begin
      r = q.pop_front();
      check("stop kind", r.k, RES_INTERVAL);
      check("stop interval", r.v, 48'(s[2*i+1] + off - s[2*i]));
      check("inhibit", r.inh, i);
    end
  endtask

  initial begin
    repeat (16) @(posedge clock_in);
    #1;
    sys_rst_in = 1'b0;
    check("ready after reset", rdy, 1'b1);
    cont_interval();
    event_rollover();
    period_ratio();
    freq_ratio();
    start_stop();
    cont_interval();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clock_in);
    n_mismatch++;
    conclude();
  end
endmodule
